/* rtl/fid_datapath.sv */
// Floating-point instruction datapath with accumulators and flags.
`timescale 1ns/1ps
module fid_datapath (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Control bits.
   input wire logic truncate_select,
   input wire logic undefined_variable_trap_enable,
   // Instruction request.
   input wire fid_pkg::fid_req_t req,
   // Accumulator view.
   input wire logic [2:0] view_sel,
   output logic [63:0] view_word,
   // Completion and memory write-back.
   output logic done,
   output logic mem_wr_valid,
   output logic [63:0] mem_wr_data,
   // Flags and trap pulses.
   output fid_pkg::fid_flags_t flags,
   output logic trap_overflow,
   output logic trap_underflow,
   output logic trap_minus_zero
);

   // Accumulator storage, flip-flops addressed by index.
   logic [63:0] acc_r [fid_pkg::NUM_ACC];

   // Output registers.
   logic done_r;
   logic mem_wr_valid_r;
   logic [63:0] mem_wr_data_r;
   fid_pkg::fid_flags_t flags_r;
   logic trap_ovf_r;
   logic trap_unf_r;
   logic trap_mz_r;
   logic [63:0] view_r;

   // Normalise sign, exponent and 48-bit mantissa (0.m times 2^(e-128)).
   // Only the single-precision fraction is kept; the low word is zero.
   function automatic fid_pkg::fid_norm_t fn_norm(input logic s,
         input logic signed [11:0] e, input logic [47:0] m);
      fid_pkg::fid_norm_t r;
      logic [5:0] lz;
      logic [47:0] ms;
      logic signed [11:0] en;
      r = '0;
      lz = 6'd0;
      for (int i = 0; i < 48; i++) begin
         if (m[i]) begin
            lz = 6'(47 - i);
         end
      end
      ms = m << lz;
      en = e - 12'(lz);
      if (m == 48'h0 || en <= 12'sd0) begin
         // Too small or exact zero: the result is a clean zero.
         r.unf = (m != 48'h0);
      end else if (en > 12'sd255) begin
         r.ovf = 1'b1;
      end else begin
         r.word = {s, en[7:0], ms[46:24], fid_pkg::LOW_ZERO};
      end
      return r;
   endfunction

   // Mantissa with hidden bit; a zero exponent means a zero value.
   function automatic logic [23:0] fn_mant(input logic [63:0] w);
      return (w[fid_pkg::EXP_HI:fid_pkg::EXP_LO] != 8'h0) ?
         {1'b1, w[fid_pkg::SFRAC_HI:fid_pkg::SFRAC_LO]} : 24'h0;
   endfunction

   // Operand selection: the source is an accumulator in mode 0, else memory.
   wire [63:0] ac_word = acc_r[req.ac_sel];
   wire [63:0] ea_word = acc_r[req.ea_sel];
   wire [63:0] src_word = req.reg_mode ? ea_word : req.mem_word;
   wire [7:0] src_exp = src_word[fid_pkg::EXP_HI:fid_pkg::EXP_LO];
   wire [7:0] ac_exp = ac_word[fid_pkg::EXP_HI:fid_pkg::EXP_LO];
   wire [23:0] src_m = fn_mant(src_word);
   wire [23:0] ac_m = fn_mant(ac_word);
   wire is_cmp = (req.op == fid_pkg::OP_CMP);

   // Add and subtract: destination minus source; compare uses source minus
   // destination so that the flags follow the source operand.
   wire sub_like = (req.op == fid_pkg::OP_SUB) || is_cmp;
   wire sa = is_cmp ? src_word[63] : ac_word[63];
   wire sb = (is_cmp ? ac_word[63] : src_word[63]) ^ sub_like;
   wire [7:0] ea = is_cmp ? src_exp : ac_exp;
   wire [7:0] eb = is_cmp ? ac_exp : src_exp;
   wire [23:0] ma = is_cmp ? src_m : ac_m;
   wire [23:0] mb = is_cmp ? ac_m : src_m;
   wire a_big = (ea > eb) || ((ea == eb) && (ma >= mb));
   wire [7:0] ediff = a_big ? (ea - eb) : (eb - ea);
   wire [47:0] mx = {1'b0, (a_big ? ma : mb), 23'h0};
   wire [47:0] my = {1'b0, (a_big ? mb : ma), 23'h0} >> ediff;
   wire [47:0] msum = (sa == sb) ? (mx + my) : (mx - my);
   wire [11:0] esum = {4'h0, (a_big ? ea : eb)} + 12'd1;
   wire fid_pkg::fid_norm_t add_n = fn_norm(a_big ? sa : sb, esum, msum);

   // Multiply, shared by modulo.
   wire [47:0] mprod = ac_m * src_m;
   wire [11:0] eprod = {4'h0, ac_exp} + {4'h0, src_exp} - 12'h080;
   wire psign = ac_word[63] ^ src_word[63];
   wire fid_pkg::fid_norm_t mul_n = fn_norm(psign, eprod, mprod);

   // Divide: quotient of the mantissas; a zero divisor overflows.
   wire div_zero = (src_m == 24'h0);
   wire [47:0] qfull = {ac_m, 24'h0} / (div_zero ? 24'h1 : src_m);
   wire [47:0] mquo = {qfull[24:0], 23'h0};
   wire [11:0] equo = {4'h0, ac_exp} - {4'h0, src_exp} + 12'h081;
   wire fid_pkg::fid_norm_t div_n = fn_norm(psign, equo, mquo);
   // Result of the four arithmetic operations, picked by operation.
   wire fid_pkg::fid_norm_t ar_n = (req.op == fid_pkg::OP_MUL) ? mul_n :
      (req.op == fid_pkg::OP_DIV) ? div_n : add_n;

   // Modulo split of the normalised product.
   wire [7:0] pexp = mul_n.word[fid_pkg::EXP_HI:fid_pkg::EXP_LO];
   wire has_whole = (pexp > fid_pkg::EXP_WHOLE);
   wire [7:0] nint = pexp - fid_pkg::EXP_BIAS;
   wire [23:0] pm = fn_mant(mul_n.word);
   wire [23:0] wmask = (nint >= 8'd24) ? 24'hffffff : ~(24'hffffff >> nint);
   wire [23:0] whole_m = pm & wmask;
   wire [47:0] frac_m = has_whole ? {pm & ~wmask, 24'h0} : {pm, 24'h0};
   wire [11:0] frac_e = {4'h0, pexp};
   wire fid_pkg::fid_norm_t frac_n = fn_norm(psign, frac_e, frac_m);
   wire [63:0] whole_w = has_whole ?
      {psign, pexp, whole_m[22:0], fid_pkg::LOW_ZERO} : fid_pkg::WORD_ZERO;
   wire [2:0] mod_even = {req.ac_sel[2:1], 1'b0};
   wire [2:0] mod_odd = {req.ac_sel[2:1], 1'b1};

   // Precision conversion: truncate or round the low word away.
   wire [31:0] hi_src = src_word[63:32];
   wire [31:0] hi_ac = ac_word[63:32];
   wire rnd_src = ~truncate_select & src_word[fid_pkg::RND_BIT];
   wire rnd_ac = ~truncate_select & ac_word[fid_pkg::RND_BIT];
   wire [63:0] load_double_to_single_w = {hi_src + {31'h0, rnd_src}, fid_pkg::LOW_ZERO};
   wire [63:0] store_double_to_single_w = {hi_ac + {31'h0, rnd_ac}, fid_pkg::LOW_ZERO};
   wire [63:0] load_single_to_double_w = {hi_src, fid_pkg::LOW_ZERO};
   wire [63:0] store_single_to_double_w = {hi_ac, fid_pkg::LOW_ZERO};
   // Plain load copies the source; converting loads reshape it.
   wire [63:0] ld_w = (req.op == fid_pkg::OP_LOAD_DOUBLE_TO_SINGLE) ? load_double_to_single_w :
      (req.op == fid_pkg::OP_LOAD_SINGLE_TO_DOUBLE) ? load_single_to_double_w : src_word;

   // Test, absolute and negate act on the target operand.
   wire [63:0] tgt_word = src_word;
   wire tgt_exp_zero = (src_exp == 8'h0);
   wire [63:0] abs_w = tgt_exp_zero ? fid_pkg::WORD_ZERO :
      {1'b0, tgt_word[62:0]};
   wire [63:0] neg_w = tgt_exp_zero ? fid_pkg::WORD_ZERO :
      {~tgt_word[63], tgt_word[62:0]};
   wire minus_zero = tgt_word[63] & tgt_exp_zero;
   // Word delivered by store, clear, absolute and negate, to either side.
   wire [63:0] dlv_w = (req.op == fid_pkg::OP_ST) ? ac_word :
      (req.op == fid_pkg::OP_STORE_DOUBLE_TO_SINGLE) ? store_double_to_single_w :
      (req.op == fid_pkg::OP_STORE_SINGLE_TO_DOUBLE) ? store_single_to_double_w :
      (req.op == fid_pkg::OP_ABS) ? abs_w :
      (req.op == fid_pkg::OP_NEG) ? neg_w : fid_pkg::WORD_ZERO;

   // Load exponent: the nine top bits must agree, and 177600 is excluded.
   wire [15:0] lx = src_word[15:0];
   wire lx_top_eq = (lx[15:7] == 9'h000) || (lx[15:7] == 9'h1ff);
   wire lx_legal = lx_top_eq && (lx != fid_pkg::LDEXP_ZERO_EXP);
   wire [7:0] lx_biased = lx[7:0] + fid_pkg::EXP_BIAS;
   wire lx_ovf = ~lx_legal & ~lx[15];
   wire lx_unf = ~lx_legal & lx[15];
   wire [63:0] ldexp_w = {ac_word[63], lx_biased, ac_word[54:0]};

   // Result selection: up to two accumulator writes and one memory write.
   logic wa_en;
   logic [2:0] wa_idx;
   logic [63:0] wa_data;
   logic wb_en;
   logic [63:0] wb_data;
   logic mw_en;
   logic [63:0] mw_data;
   logic [63:0] flag_word;
   logic keep_flags;
   logic f_ovf;
   logic f_unf;

   // Every operation decodes here; flags follow the produced word, except plain store, which keeps them.
   always_comb begin
      wa_en = 1'b0;
      wa_idx = req.ac_sel;
      wa_data = fid_pkg::WORD_ZERO;
      wb_en = 1'b0;
      wb_data = fid_pkg::WORD_ZERO;
      mw_en = 1'b0;
      mw_data = fid_pkg::WORD_ZERO;
      flag_word = fid_pkg::WORD_ZERO;
      keep_flags = 1'b0;
      f_ovf = 1'b0;
      f_unf = 1'b0;
      unique case (req.op)
         fid_pkg::OP_ADD, fid_pkg::OP_SUB, fid_pkg::OP_MUL,
               fid_pkg::OP_DIV: begin
            wa_en = 1'b1;
            wa_data = ar_n.word;
            f_ovf = ar_n.ovf | (div_zero && req.op == fid_pkg::OP_DIV);
            f_unf = ar_n.unf;
         end
         fid_pkg::OP_CMP: begin
            // Only the flags change; neither operand is touched.
            flag_word = add_n.word;
         end
         fid_pkg::OP_MOD: begin
            wa_en = 1'b1;
            wa_idx = mod_even;
            wa_data = frac_n.word;
            wb_en = 1'b1;
            wb_data = whole_w;
            f_ovf = mul_n.ovf;
            f_unf = mul_n.unf | frac_n.unf;
         end
         fid_pkg::OP_LD, fid_pkg::OP_LOAD_DOUBLE_TO_SINGLE, fid_pkg::OP_LOAD_SINGLE_TO_DOUBLE: begin
            wa_en = 1'b1;
            wa_data = ld_w;
         end
         fid_pkg::OP_ST, fid_pkg::OP_STORE_DOUBLE_TO_SINGLE, fid_pkg::OP_STORE_SINGLE_TO_DOUBLE,
               fid_pkg::OP_CLR, fid_pkg::OP_ABS, fid_pkg::OP_NEG: begin
            // Mode 0 writes the target accumulator, otherwise memory.
            keep_flags = (req.op == fid_pkg::OP_ST);
            wa_en = req.reg_mode;
            wa_idx = req.ea_sel;
            wa_data = dlv_w;
            mw_en = ~req.reg_mode;
            mw_data = dlv_w;
         end
         fid_pkg::OP_TST: begin
            flag_word = tgt_word;
         end
         fid_pkg::OP_LDEXP: begin
            wa_en = lx_legal;
            wa_data = ldexp_w;
            f_ovf = lx_ovf;
            f_unf = lx_unf;
         end
         default: begin
            keep_flags = 1'b1;
         end
      endcase
      if (req.op != fid_pkg::OP_CMP && req.op != fid_pkg::OP_TST) begin
         flag_word = wa_en ? wa_data : mw_data;
      end
   end

   // Per-entry accumulator write; the whole part of modulo uses port b.
   for (genvar g = 0; g < fid_pkg::NUM_ACC; g++) begin : g_acc
      wire hit_a = req.valid && wa_en && (wa_idx == 3'(g));
      wire hit_b = req.valid && wb_en && (mod_odd == 3'(g));
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            acc_r[g] <= fid_pkg::WORD_ZERO;
         end else if (hit_b) begin
            acc_r[g] <= wb_data;
         end else if (hit_a) begin
            acc_r[g] <= wa_data;
         end
      end
   end

   // Next flag values; carry is always clear, and test clears overflow explicitly.
   fid_pkg::fid_flags_t flags_nxt;
   assign flags_nxt.carry = 1'b0;
   assign flags_nxt.ovf = (req.op == fid_pkg::OP_TST) ? 1'b0 : f_ovf;
   assign flags_nxt.neg = flag_word[fid_pkg::SIGN_BIT];
   assign flags_nxt.zero =
      (flag_word[fid_pkg::EXP_HI:fid_pkg::EXP_LO] == 8'h0);
   wire mz_trap = (req.op == fid_pkg::OP_TST) &&
      undefined_variable_trap_enable && minus_zero;

   // Status, traps and memory write-back, registered for clean outputs.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         done_r <= 1'b0;
         mem_wr_valid_r <= 1'b0;
         mem_wr_data_r <= fid_pkg::WORD_ZERO;
         flags_r <= '0;
         trap_ovf_r <= 1'b0;
         trap_unf_r <= 1'b0;
         trap_mz_r <= 1'b0;
      end else begin
         done_r <= req.valid;
         mem_wr_valid_r <= req.valid && mw_en;
         trap_ovf_r <= req.valid && f_ovf;
         trap_unf_r <= req.valid && f_unf;
         trap_mz_r <= req.valid && mz_trap;
         if (req.valid && mw_en) begin
            mem_wr_data_r <= mw_data;
         end
         if (req.valid && !keep_flags) begin
            flags_r <= flags_nxt;
         end
      end
   end

   // Read-back of one accumulator, one cycle behind the select.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         view_r <= fid_pkg::WORD_ZERO;
      end else begin
         view_r <= acc_r[view_sel];
      end
   end

   assign view_word = view_r;
   assign done = done_r;
   assign mem_wr_valid = mem_wr_valid_r;
   assign mem_wr_data = mem_wr_data_r;
   assign flags = flags_r;
   assign trap_overflow = trap_ovf_r;
   assign trap_underflow = trap_unf_r;
   assign trap_minus_zero = trap_mz_r;

   // Checks on the datapath outputs.
   sequence s_mem_req(fid_pkg::fid_op_t o);
      req.valid && !req.reg_mode && req.op == o;
   endsequence

   AST_CLR_MEM:
      assert property (@(posedge sys_clk) disable iff (reset)
         s_mem_req(fid_pkg::OP_CLR) |=> mem_wr_valid && mem_wr_data == 64'h0)
      else $error("clear did not write a zero word");
   AST_TST_FLAGS:
      assert property (@(posedge sys_clk) disable iff (reset)
         req.valid && req.op == fid_pkg::OP_TST |=> !flags.carry &&
         !flags.ovf && flags.neg == $past(tgt_word[63]) &&
         flags.zero == $past(tgt_exp_zero))
      else $error("test flags wrong");
   AST_MINUS_ZERO:
      assert property (@(posedge sys_clk) disable iff (reset)
         req.valid && req.op == fid_pkg::OP_TST &&
         undefined_variable_trap_enable && minus_zero |=> trap_minus_zero)
      else $error("minus zero trap missing");
   AST_LDEXP_OVF:
      assert property (@(posedge sys_clk) disable iff (reset)
         req.valid && req.op == fid_pkg::OP_LDEXP && !lx_top_eq &&
         !lx[15] |=> trap_overflow && !trap_underflow)
      else $error("load exponent overflow missing");
   AST_LDEXP_EXP0:
      assert property (@(posedge sys_clk) disable iff (reset)
         req.valid && req.op == fid_pkg::OP_LDEXP &&
         lx == fid_pkg::LDEXP_ZERO_EXP |=> trap_underflow)
      else $error("load exponent 177600 not underflow");
   AST_CMP_NOWRITE:
      assert property (@(posedge sys_clk) disable iff (reset)
         req.valid && is_cmp |=> !mem_wr_valid)
      else $error("compare wrote memory");
   AST_ABS_SIGN:
      assert property (@(posedge sys_clk) disable iff (reset)
         s_mem_req(fid_pkg::OP_ABS) |=> mem_wr_valid && !mem_wr_data[63])
      else $error("absolute left sign set");
   AST_NEG_ZERO:
      assert property (@(posedge sys_clk) disable iff (reset)
         s_mem_req(fid_pkg::OP_NEG) ##0 tgt_exp_zero |=>
         mem_wr_data == 64'h0)
      else $error("negate of zero exponent not zeroed");
   AST_ROUND:
      assert property (@(posedge sys_clk) disable iff (reset)
         s_mem_req(fid_pkg::OP_STORE_DOUBLE_TO_SINGLE) ##0 !truncate_select |=>
         mem_wr_data[63:32] == $past(hi_ac) + {31'h0, $past(ac_word[31])})
      else $error("rounding wrong");
   AST_ONE_DIR:
      assert property (@(posedge sys_clk) disable iff (reset)
         req.valid && (req.op == fid_pkg::OP_LD ||
         req.op == fid_pkg::OP_TST) |=> !mem_wr_valid)
      else $error("read-only operation wrote memory");

endmodule // fid_datapath

/* rtl/fid_pkg.sv */
// Constants, operation codes and carrier structs for the float datapath.
package fid_pkg;

   // Word layout: sign, biased exponent, fraction; single is the high word.
   localparam int SIGN_BIT = 63;
   localparam int EXP_HI = 62;
   localparam int EXP_LO = 55;
   localparam int SFRAC_HI = 54;
   localparam int SFRAC_LO = 32;
   localparam int RND_BIT = 31;
   localparam int NUM_ACC = 6;

   // Exponent bias (200 octal) and the whole-number boundary (201 octal).
   localparam logic [7:0] EXP_BIAS = 8'h80;
   localparam logic [7:0] EXP_WHOLE = 8'h81;
   // The one input whose top bits agree but is still illegal (177600 octal).
   localparam logic [15:0] LDEXP_ZERO_EXP = 16'hff80;
   localparam logic [63:0] WORD_ZERO = 64'h0;
   localparam logic [31:0] LOW_ZERO = 32'h0;

   // Operations the datapath carries out.
   typedef enum logic [4:0] {
      OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CMP, OP_MOD, OP_LD, OP_ST,
      OP_LOAD_DOUBLE_TO_SINGLE, OP_LOAD_SINGLE_TO_DOUBLE, OP_STORE_DOUBLE_TO_SINGLE, OP_STORE_SINGLE_TO_DOUBLE, OP_CLR, OP_TST, OP_ABS,
      OP_NEG, OP_LDEXP
   } fid_op_t;

   // One instruction as handed over by the host processor.
   typedef struct packed {
      logic valid;         // Request strobe, one cycle.
      fid_op_t op;         // Operation.
      logic reg_mode;      // High for register mode 0.
      logic [2:0] ac_sel;  // Accumulator field.
      logic [2:0] ea_sel;  // Accumulator used as source/target in mode 0.
      logic [63:0] mem_word; // Operand fetched from memory by the host.
   } fid_req_t;

   // Condition flags.
   typedef struct packed {
      logic neg;
      logic zero;
      logic ovf;
      logic carry;
   } fid_flags_t;

   // Result of the shared normaliser.
   typedef struct packed {
      logic [63:0] word;
      logic ovf;
      logic unf;
   } fid_norm_t;

endpackage

/* tb/fid_host_model.sv */
// Host side model: operand memory that fetches and takes write-backs.
`timescale 1ns/1ps
module fid_host_model (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Operand fetch.
   input wire logic fetch,
   input wire logic [2:0] addr,
   output logic [63:0] mem_word,
   // Write-back from the device.
   input wire logic mem_wr_valid,
   input wire logic [63:0] mem_wr_data
);
   logic [63:0] mem [8]; // Operand memory, preset by the bench.
   logic [2:0] addr_r; // Word fetched last, target of a write-back.
   // Cleared at start so the bus never carries unknowns.
   initial begin
      for (int i = 0; i < 8; i++) begin
         mem[i] = 64'h0;
      end
   end
   // Outside a fetch the bus shows the inverse, so stale data cannot pass.
   assign mem_word = fetch ? mem[addr] : ~mem[addr];
   // The write-back lands one cycle after the fetch, so keep its address.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         addr_r <= 3'h0;
      end else if (fetch) begin
         addr_r <= addr;
      end
   end
   // Plain always: the bench also presets words here between requests.
   always @(posedge sys_clk) begin
      if (mem_wr_valid) begin
         mem[addr_r] <= mem_wr_data;
      end
   end
endmodule // fid_host_model

/* tb/test_float_instruction_datapath.sv */
// Self-checking bench for the float datapath.
`timescale 1ns/1ps
module test_float_instruction_datapath;
   logic sys_clk = 1'b0; // 250 MHz.
   logic reset = 1'b1;
   logic truncate_select = 1'b0;
   logic undefined_variable_trap_enable = 1'b0;
   logic rq_valid = 1'b0;
   fid_pkg::fid_op_t rq_op = fid_pkg::OP_LD;
   logic rq_mode = 1'b0;
   logic [2:0] rq_ac = 3'h0;
   logic [2:0] rq_ea = 3'h0;
   logic fetch = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [2:0] view_sel = 3'h0;
   logic [63:0] host_word, view_word, mem_wr_data, g_wd;
   logic done, mem_wr_valid, trap_overflow, trap_underflow, trap_minus_zero;
   logic [3:0] g_ev; // Answer events: write, overflow, underflow, minus 0.
   fid_pkg::fid_flags_t flags;
   fid_pkg::fid_req_t req;
   int n_errors = 0;
   int tests_run = 0;
   localparam logic [63:0] HALF = 64'h4000_0000_0000_0000;
   localparam logic [63:0] ONE = 64'h4080_0000_0000_0000;
   localparam logic [63:0] TWO = 64'h4100_0000_0000_0000;
   localparam logic [63:0] TWOH = 64'h4120_0000_0000_0000;

   // The operand travels with the request, straight from the host.
   assign req = {rq_valid, rq_op, rq_mode, rq_ac, rq_ea, host_word};
   always #2 sys_clk = ~sys_clk;

   fid_datapath fid_datapath_i (.sys_clk(sys_clk), .reset(reset),
      .truncate_select(truncate_select),
      .undefined_variable_trap_enable(undefined_variable_trap_enable),
      .req(req), .view_sel(view_sel), .view_word(view_word),
      .done(done), .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
      .flags(flags), .trap_overflow(trap_overflow),
      .trap_underflow(trap_underflow), .trap_minus_zero(trap_minus_zero));
   fid_host_model fid_host_model_i (.sys_clk(sys_clk), .reset(reset),
      .fetch(fetch), .addr(addr), .mem_word(host_word),
      .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data));

   // Count one compare and report a mismatch at once.
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Print the counts and the verdict, then stop.
   task automatic end_sim();
      $display("mismatches %0d compares %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Preset a host memory word.
   task automatic put(input logic [2:0] a, input logic [63:0] v);
      fid_host_model_i.mem[a] = v;
   endtask

   // One request; the answer pulses stand only in the next cycle.
   task automatic issue(input fid_pkg::fid_op_t op, input logic md,
         input logic [2:0] ac, input logic [2:0] ea, input logic [2:0] a);
      @(negedge sys_clk);
      rq_op = op;
      rq_mode = md;
      rq_ac = ac;
      rq_ea = ea;
      addr = a;
      fetch = 1'b1;
      rq_valid = 1'b1;
      @(negedge sys_clk);
      rq_valid = 1'b0;
      fetch = 1'b0;
      chk(done, 1'b1);
      g_ev = {mem_wr_valid, trap_overflow, trap_underflow, trap_minus_zero};
      g_wd = mem_wr_data;
   endtask

   // Read an accumulator back; the view lags its select by a cycle.
   task automatic ca(input logic [2:0] i, input logic [63:0] e);
      @(negedge sys_clk);
      view_sel = i;
      @(negedge sys_clk);
      chk(view_word, e);
   endtask

   // Load a memory word into an accumulator.
   task automatic ldm(input logic [2:0] i, input logic [63:0] v);
      put(3'h0, v);
      issue(fid_pkg::OP_LD, 1'b0, i, 3'h0, 3'h0);
      chk(g_ev, 4'h0);
   endtask

   task automatic t_reset();
      for (int i = 0; i < 6; i++) begin
         ca(3'(i), 64'h0);
      end
      chk(flags, 4'h0);
   endtask

   task automatic t_arith();
      ldm(3'h0, HALF);
      ldm(3'h1, HALF);
      issue(fid_pkg::OP_ADD, 1'b1, 3'h1, 3'h0, 3'h0);
      ca(3'h1, ONE);
      chk(flags, 4'h0);
      put(3'h1, TWOH);
      issue(fid_pkg::OP_MUL, 1'b0, 3'h1, 3'h0, 3'h1);
      ca(3'h1, TWOH);
      issue(fid_pkg::OP_CMP, 1'b1, 3'h1, 3'h0, 3'h0);
      chk(g_ev, 4'h0);
      chk(flags, 4'h8);
      ca(3'h1, TWOH);
      ca(3'h0, HALF);
      ldm(3'h2, TWOH);
      put(3'h0, ONE);
      issue(fid_pkg::OP_MOD, 1'b0, 3'h2, 3'h0, 3'h0);
      ca(3'h2, HALF);
      ca(3'h3, TWO);
      // Two minus one half, then that over one half, then a zero divisor.
      issue(fid_pkg::OP_SUB, 1'b1, 3'h3, 3'h2, 3'h0);
      ca(3'h3, 64'h40c0_0000_0000_0000);
      issue(fid_pkg::OP_DIV, 1'b1, 3'h3, 3'h2, 3'h0);
      ca(3'h3, 64'h4140_0000_0000_0000);
      put(3'h0, 64'h0);
      issue(fid_pkg::OP_DIV, 1'b0, 3'h3, 3'h0, 3'h0);
      chk(g_ev, 4'h4);
      ca(3'h3, 64'h0);
   endtask

   task automatic t_conv();
      truncate_select = 1'b1;
      ldm(3'h4, 64'h4080_0000_8000_0000);
      issue(fid_pkg::OP_LOAD_DOUBLE_TO_SINGLE, 1'b0, 3'h4, 3'h0, 3'h0);
      ca(3'h4, ONE);
      truncate_select = 1'b0;
      issue(fid_pkg::OP_LOAD_DOUBLE_TO_SINGLE, 1'b0, 3'h4, 3'h0, 3'h0);
      ca(3'h4, 64'h4080_0001_0000_0000);
      put(3'h0, 64'h4080_0000_7fff_ffff);
      issue(fid_pkg::OP_LOAD_DOUBLE_TO_SINGLE, 1'b0, 3'h4, 3'h0, 3'h0);
      ca(3'h4, ONE);
      put(3'h0, 64'h4080_0001_1234_5678);
      issue(fid_pkg::OP_LOAD_SINGLE_TO_DOUBLE, 1'b0, 3'h5, 3'h0, 3'h0);
      ca(3'h5, 64'h4080_0001_0000_0000);
      ldm(3'h4, 64'h40c0_0002_ffff_ffff);
      issue(fid_pkg::OP_STORE_DOUBLE_TO_SINGLE, 1'b0, 3'h4, 3'h0, 3'h2);
      chk(g_ev, 4'h8);
      chk(g_wd, 64'h40c0_0003_0000_0000);
      issue(fid_pkg::OP_STORE_SINGLE_TO_DOUBLE, 1'b1, 3'h4, 3'h5, 3'h0);
      ca(3'h5, 64'h40c0_0002_0000_0000);
   endtask

   task automatic t_store();
      logic [3:0] f;
      ldm(3'h1, 64'hc080_0000_0000_0001);
      issue(fid_pkg::OP_ST, 1'b1, 3'h1, 3'h5, 3'h0);
      ca(3'h5, 64'hc080_0000_0000_0001);
      f = flags;
      issue(fid_pkg::OP_ST, 1'b0, 3'h1, 3'h0, 3'h3);
      chk(g_wd, 64'hc080_0000_0000_0001);
      chk(flags, f);
      issue(fid_pkg::OP_CLR, 1'b1, 3'h0, 3'h5, 3'h0);
      ca(3'h5, 64'h0);
      chk(flags, 4'h4);
      issue(fid_pkg::OP_CLR, 1'b0, 3'h0, 3'h0, 3'h3);
      chk(g_ev, 4'h8);
      ca(3'h0, HALF);
      chk(fid_host_model_i.mem[3], 64'h0);
   endtask

   task automatic t_absneg();
      fid_pkg::fid_op_t op[4];
      logic [63:0] vi[4];
      logic [63:0] vo[4];
      op = '{fid_pkg::OP_ABS, fid_pkg::OP_ABS, fid_pkg::OP_NEG,
             fid_pkg::OP_NEG};
      vi = '{64'hc080_0001_0000_0000, 64'h8000_0000_1234_5678,
             64'h4080_0000_0000_0001, 64'h007f_ffff_0000_0000};
      vo = '{64'h4080_0001_0000_0000, 64'h0, 64'hc080_0000_0000_0001,
             64'h0};
      for (int i = 0; i < 4; i++) begin
         put(3'h4, vi[i]);
         issue(op[i], 1'b0, 3'h0, 3'h0, 3'h4);
         chk(g_ev, 4'h8);
         chk(g_wd, vo[i]);
         ldm(3'h0, vi[i]);
         issue(op[i], 1'b1, 3'h0, 3'h0, 3'h0);
         ca(3'h0, vo[i]);
      end
   endtask

   task automatic t_test();
      undefined_variable_trap_enable = 1'b1;
      put(3'h0, 64'h8000_0000_0000_0000);
      issue(fid_pkg::OP_TST, 1'b0, 3'h0, 3'h0, 3'h0);
      chk(flags, 4'hc);
      chk(g_ev, 4'h1);
      undefined_variable_trap_enable = 1'b0;
      issue(fid_pkg::OP_TST, 1'b0, 3'h0, 3'h0, 3'h0);
      chk(g_ev, 4'h0);
      put(3'h0, ONE);
      issue(fid_pkg::OP_TST, 1'b0, 3'h0, 3'h0, 3'h0);
      chk(flags, 4'h0);
   endtask

   task automatic t_ldexp();
      logic [63:0] b;
      logic [15:0] vi[6];
      logic [7:0] ex[6];
      logic [3:0] ev[6];
      b = 64'hc080_0001_2345_6789;
      vi = '{16'h001c, 16'h007f, 16'hff81, 16'h0081, 16'h8080, 16'hff80};
      ex = '{8'h9c, 8'hff, 8'h01, 8'h0, 8'h0, 8'h0};
      ev = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h2, 4'h2};
      for (int i = 0; i < 6; i++) begin
         ldm(3'h3, b);
         put(3'h0, {48'h0, vi[i]});
         issue(fid_pkg::OP_LDEXP, 1'b0, 3'h3, 3'h0, 3'h0);
         chk(g_ev, ev[i]);
         ca(3'h3, (i < 3) ? {b[63], ex[i], b[54:0]} : b);
      end
   endtask

   // Reset for eight cycles, then run each scenario in turn.
   initial begin
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      t_reset();
      t_arith();
      t_conv();
      t_store();
      t_absneg();
      t_ldexp();
      t_test();
      end_sim();
   end
endmodule // test_float_instruction_datapath
